//--- core/aie_pkg.sv
package aie_pkg;

  // ****************************************************************
  // opcode fields
  // ****************************************************************
  localparam logic [7:0]  OPC_ADD_LITERAL    = 8'h0F;    // 0000 1111 kkkk kkkk
  localparam logic [5:0]  OPC_ADD_ACC_FILE   = 6'h09;    // 0010 01da ffff ffff
  localparam int          DEST_BIT           = 9;
  localparam int          BANK_BIT           = 8;
  localparam logic [7:0]  INDEXED_LIMIT      = 8'h5F;    // 95
  localparam logic [3:0]  ACCESS_HIGH_BANK   = 4'hF;
  localparam logic [7:0]  ACCESS_SPLIT       = 8'h60;
  localparam logic [7:0]  ACC_RESET          = 8'h00;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b11,
    PH_WRITE   = 2'b10
  } aie_phase_t;

  typedef struct packed {
    logic negative;
    logic overflow_flag;
    logic zero;
    logic digit_carry_flag;
    logic carry;
  } aie_flags_t;

  typedef struct packed {
    logic        en;
    logic [11:0] addr;
  } aie_mem_req_t;

endpackage

//--- core/aie_adder.sv
`timescale 1ns/10ps

// ****************************************************************
// 8-bit add with status flags
// ****************************************************************
module aie_adder
  import aie_pkg::*;
(
  // operands
  input  wire logic [7:0] op_a,
  input  wire logic [7:0] op_b,
  // result
  output      logic [7:0] sum,
  output      aie_flags_t flags
);

  logic [4:0] low_nib;
  logic [8:0] full;

  always_comb begin
    low_nib = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
    full    = {1'b0, op_a} + {1'b0, op_b};
    sum     = full[7:0];
    flags.carry            = full[8];
    flags.digit_carry_flag = low_nib[4];
    flags.zero             = (full[7:0] == 8'h00);
    flags.negative         = full[7];
    flags.overflow_flag    = (op_a[7] == op_b[7]) && (full[7] != op_a[7]);
  end

endmodule

//--- core/aie_core.sv
`timescale 1ns/10ps

module aie_core
  import aie_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  // instruction in, taken at decode phase
  input  wire logic         instr_valid,
  input  wire logic [15:0]  instr_word,
  // configuration
  input  wire logic [3:0]   bank_select_reg,
  input  wire logic         ext_set_en,
  input  wire logic [11:0]  index_base,
  // data memory
  input  wire logic [7:0]   mem_rdata,
  output      aie_mem_req_t mem_rd_ff,
  output      aie_mem_req_t mem_wr_ff,
  output      logic [7:0]   mem_wdata_ff,
  // status
  output      logic [7:0]   accumulator_reg_ff,
  output      aie_flags_t   flags_ff,
  output      logic         flags_upd_ff,
  output      logic         busy_ff,
  output      logic         done_ff,
  output      logic         illegal_ff
);

  // ****************************************************************
  // decode
  // ****************************************************************
  aie_phase_t  phase_ff;
  aie_phase_t  nxt_phase;
  logic        is_lit_ff;
  logic        dest_file_ff;
  logic [7:0]  lit_ff;
  logic [11:0] addr_ff;
  logic [7:0]  operand_ff;
  logic [7:0]  sum_ff;
  aie_flags_t  res_flags_ff;
  logic        is_lit;
  logic        is_file;
  logic        bank_bit;
  logic [7:0]  f_field;
  logic [11:0] nxt_addr;
  logic [7:0]  add_sum;
  aie_flags_t  add_flags;

  assign is_lit   = instr_word[15:8] == OPC_ADD_LITERAL;
  assign is_file  = instr_word[15:10] == OPC_ADD_ACC_FILE;
  assign bank_bit = instr_word[BANK_BIT];
  assign f_field  = instr_word[7:0];

  // priority: bank select, then indexed window, then split access bank
  // indexed sum wraps inside 12 bits; a base near the top folds back to page 0
  // the window check only applies with the bank bit low
  always_comb begin
    if (bank_bit) begin
      nxt_addr = {bank_select_reg, f_field};
    end else if (ext_set_en && (f_field <= INDEXED_LIMIT)) begin
      nxt_addr = index_base + {4'h0, f_field};
    end else if (f_field >= ACCESS_SPLIT) begin
      nxt_addr = {ACCESS_HIGH_BANK, f_field};
    end else begin
      nxt_addr = {4'h0, f_field};
    end
  end

  // ****************************************************************
  // phase sequencer
  // ****************************************************************
  // a non-add word stays in decode: no operand read, no write
  always_comb begin
    unique case (phase_ff)
      PH_DECODE: begin
        nxt_phase = (instr_valid && (is_lit || is_file)) ? PH_READ : PH_DECODE;
      end
      PH_READ: begin
        nxt_phase = PH_PROCESS;
      end
      PH_PROCESS: begin
        nxt_phase = PH_WRITE;
      end
      PH_WRITE: begin
        nxt_phase = PH_DECODE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_ff <= PH_DECODE;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // from the next phase so busy drops on the write edge, in time for a back-to-back word
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_phase != PH_DECODE;
    end
  end

  // decode latches the word so the caller may change it afterwards
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      is_lit_ff    <= 1'b0;
      dest_file_ff <= 1'b0;
      lit_ff       <= 8'h00;
      addr_ff      <= 12'h000;
    end else if (phase_ff == PH_DECODE && instr_valid) begin
      is_lit_ff    <= is_lit;
      dest_file_ff <= is_file && instr_word[DEST_BIT];
      lit_ff       <= f_field;
      addr_ff      <= nxt_addr;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= phase_ff == PH_DECODE && instr_valid && !is_lit && !is_file;
    end
  end

  // ****************************************************************
  // operand read
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_rd_ff <= '0;
    end else begin
      mem_rd_ff.en   <= nxt_phase == PH_READ && !is_lit;
      mem_rd_ff.addr <= (nxt_phase == PH_READ) ? nxt_addr : 12'h000;
    end
  end

  // memory answers combinationally while the read strobe is up
  // a literal never raises the strobe, its operand comes from the decode latch
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      operand_ff <= 8'h00;
    end else if (phase_ff == PH_READ) begin
      operand_ff <= is_lit_ff ? lit_ff : mem_rdata;
    end
  end

  // ****************************************************************
  // process
  // ****************************************************************
  aie_adder u_adder (
    .op_a  (accumulator_reg_ff),
    .op_b  (operand_ff),
    .sum   (add_sum),
    .flags (add_flags)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sum_ff       <= 8'h00;
      res_flags_ff <= '0;
    end else if (phase_ff == PH_PROCESS) begin
      sum_ff       <= add_sum;
      res_flags_ff <= add_flags;
    end
  end

  // ****************************************************************
  // write to destination
  // ****************************************************************
  // accumulator and flags move on one edge, so a reader never sees a mixed pair
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      accumulator_reg_ff <= ACC_RESET;
    end else if (phase_ff == PH_WRITE && !dest_file_ff) begin
      accumulator_reg_ff <= sum_ff;
    end
  end

  // strobe raised in process so memory takes the byte on the write-phase edge;
  // address and data drop to zero outside the write phase to keep the bus quiet
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mem_wr_ff    <= '0;
      mem_wdata_ff <= 8'h00;
    end else begin
      mem_wr_ff.en   <= phase_ff == PH_PROCESS && dest_file_ff;
      mem_wr_ff.addr <= (phase_ff == PH_PROCESS) ? addr_ff : 12'h000;
      mem_wdata_ff   <= (phase_ff == PH_PROCESS) ? add_sum : 8'h00;
    end
  end

  // ****************************************************************
  // status
  // ****************************************************************
  // flags follow the arithmetic of both adds
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flags_ff     <= '0;
      flags_upd_ff <= 1'b0;
      done_ff      <= 1'b0;
    end else begin
      flags_upd_ff <= phase_ff == PH_PROCESS;
      done_ff      <= phase_ff == PH_WRITE;
      if (phase_ff == PH_WRITE) begin
        flags_ff <= res_flags_ff;
      end
    end
  end

endmodule

//--- dv/aie_core_properties.sv
`timescale 1ns/10ps
// ****
// core checks
// ****
module aie_core_properties
  import aie_pkg::*;
(
  // observed ports
  input wire logic         clk_sys,
  input wire logic         rst_b,
  input wire logic [15:0]  instr_word,
  input wire logic [3:0]   bank_select_reg,
  input wire aie_mem_req_t mem_rd_ff,
  input wire aie_mem_req_t mem_wr_ff,
  input wire logic [7:0]   accumulator_reg_ff,
  input wire aie_flags_t   flags_ff,
  input wire logic         flags_upd_ff,
  input wire logic         busy_ff,
  input wire logic         done_ff
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_exec;
    busy_ff [*3] ##1 (!busy_ff && done_ff);
  endsequence
  a_busy_span: assert property ($rose(busy_ff) |-> s_exec)
    else $error("busy span wrong");
  a_rd_pulse: assert property (mem_rd_ff.en |=> !mem_rd_ff.en ##2 done_ff)
    else $error("read pulse wrong");
  a_upd_done: assert property (flags_upd_ff |=> done_ff && !flags_upd_ff)
    else $error("update not closed");
  a_wr_addr: assert property (mem_wr_ff.en |-> flags_upd_ff && mem_wr_ff.addr == $past(mem_rd_ff.addr, 2))
    else $error("write address wrong");
  a_wr_acc_hold: assert property (mem_wr_ff.en |=> $stable(accumulator_reg_ff))
    else $error("accumulator moved");
  a_acc_cause: assert property (!$stable(accumulator_reg_ff) |-> $past(flags_upd_ff))
    else $error("accumulator moved alone");
  a_flag_cause: assert property (!$stable(flags_ff) |-> $past(flags_upd_ff))
    else $error("flags moved alone");
  a_bank_addr: assert property (mem_rd_ff.en && $past(instr_word[BANK_BIT]) |->
    mem_rd_ff.addr == {$past(bank_select_reg), $past(instr_word[7:0])}) else $error("bank address wrong");
endmodule
bind aie_core aie_core_properties i_props (.clk_sys(clk_sys), .rst_b(rst_b), .instr_word(instr_word),
  .bank_select_reg(bank_select_reg), .mem_rd_ff(mem_rd_ff), .mem_wr_ff(mem_wr_ff),
  .accumulator_reg_ff(accumulator_reg_ff), .flags_ff(flags_ff), .flags_upd_ff(flags_upd_ff),
  .busy_ff(busy_ff), .done_ff(done_ff));

//--- dv/aie_mem_model.sv
`timescale 1ns/10ps
// ****
// data memory stand-in
// ****
module aie_mem_model
  import aie_pkg::*;
(
  // core side
  input  wire logic         clk_sys,
  input  wire aie_mem_req_t mem_rd,
  input  wire aie_mem_req_t mem_wr,
  input  wire logic [7:0]   mem_wdata,
  output      logic [7:0]   mem_rdata
);
  logic [7:0] mem [4096];
  logic [7:0] last_ff;
  initial begin
    last_ff = 8'h00;
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)} ^ 8'h3C;
    end
  end
  // idle bus shows inverted last byte, so a stale read never matches
  assign mem_rdata = mem_rd.en ? mem[mem_rd.addr] : ~last_ff;
  always @(posedge clk_sys) begin
    last_ff <= mem_rdata;
    if (mem_wr.en) mem[mem_wr.addr] <= mem_wdata;
  end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
  import aie_pkg::*;
;
  typedef struct packed {logic [15:0] w; logic [3:0] b; logic e; logic [11:0] a;} aie_row_t;
  localparam aie_row_t ROWS [8] = '{
    '{16'h0F15, 4'h0, 1'b0, 12'h000},
    '{16'h0F7F, 4'h0, 1'b0, 12'h000},
    '{16'h2540, 4'h3, 1'b0, 12'h340},
    '{16'h27C8, 4'h5, 1'b1, 12'h5C8},
    '{16'h245F, 4'h7, 1'b0, 12'h05F},
    '{16'h2480, 4'h7, 1'b0, 12'hF80},
    '{16'h245F, 4'h7, 1'b1, 12'h25F},
    '{16'h2660, 4'h7, 1'b1, 12'hF60}};
  logic         clk_sys, rst_b, instr_valid, ext_set_en, upd, busy_ff, done_ff, illegal_ff, lit;
  logic [15:0]  instr_word;
  logic [3:0]   bank_select_reg;
  logic [11:0]  ib;
  logic [7:0]   mem_rdata, mem_wdata, acc, acc_m, s, op;
  aie_mem_req_t mem_rd, mem_wr;
  aie_flags_t   flags, fl;
  int           n_fail, checks, n_ill;
  aie_core i_aie_core (.clk_sys(clk_sys), .rst_b(rst_b), .instr_valid(instr_valid), .instr_word(instr_word),
    .bank_select_reg(bank_select_reg), .ext_set_en(ext_set_en), .index_base(ib), .mem_rdata(mem_rdata),
    .mem_rd_ff(mem_rd), .mem_wr_ff(mem_wr), .mem_wdata_ff(mem_wdata), .accumulator_reg_ff(acc),
    .flags_ff(flags), .flags_upd_ff(upd), .busy_ff(busy_ff), .done_ff(done_ff), .illegal_ff(illegal_ff));
  aie_mem_model i_aie_mem_model (.clk_sys(clk_sys), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
  function automatic logic [12:0] add_exp(input logic [7:0] x, input logic [7:0] y);
    logic [8:0] t;
    logic [4:0] h;
    t = {1'b0, x} + {1'b0, y};
    h = {1'b0, x[3:0]} + {1'b0, y[3:0]};
    return {t[7], x[7] == y[7] && t[7] != x[7], t[7:0] == 8'h00, h[4], t[8], t[7:0]};
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // bounded wait: a missing finish shows up as a count mismatch
  task automatic issue(input logic [15:0] w, input logic [3:0] b, input logic e, input int hold, input int nd);
    int cnt;
    cnt = 0;
    @(negedge clk_sys);
    instr_word = w;
    bank_select_reg = b;
    ext_set_en = e;
    instr_valid = 1'b1;
    for (int i = 1; i <= 16; i++) begin
      @(negedge clk_sys);
      if (i == hold) instr_valid = 1'b0;
      cnt += int'(done_ff);
      n_ill += int'(illegal_ff);
      if (i >= hold && cnt == nd) break;
    end
    chk(16'(cnt), 16'(nd));
  endtask
  task automatic test_done();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  initial begin
    {rst_b, instr_valid, ext_set_en, instr_word, bank_select_reg} = '0;
    ib = 12'h200;
    {n_fail, checks, n_ill, acc_m} = '0;
    repeat (20) @(negedge clk_sys);
    rst_b = 1'b1;
    for (int r = 0; r < 8; r++) begin
      lit = ROWS[r].w[15:8] == OPC_ADD_LITERAL;
      op = lit ? ROWS[r].w[7:0] : i_aie_mem_model.mem[ROWS[r].a];
      {fl, s} = add_exp(acc_m, op);
      issue(ROWS[r].w, ROWS[r].b, ROWS[r].e, 1, 1);
      if (!lit) chk({8'h00, i_aie_mem_model.mem[ROWS[r].a]}, {8'h00, ROWS[r].w[DEST_BIT] ? s : op});
      if (lit || !ROWS[r].w[DEST_BIT]) acc_m = s;
      chk({8'h00, acc}, {8'h00, acc_m});
      chk({11'h000, flags}, {11'h000, fl});
      $display("row %0d done", r);
    end
    // valid held across busy: refused while busy, then taken back to back
    {fl, s} = add_exp(acc_m, 8'h01);
    {fl, s} = add_exp(s, 8'h01);
    acc_m = s;
    issue(16'h0F01, 4'h0, 1'b0, 8, 2);
    chk({8'h00, acc}, {8'h00, acc_m});
    chk({11'h000, flags}, {11'h000, fl});
    $display("back to back done");
    issue(16'h0E12, 4'h0, 1'b0, 1, 0);
    chk(16'(n_ill), 16'h0001);
    chk({8'h00, acc}, {8'h00, acc_m});
    $display("non-add done");
    // indexed offset must follow the base input, not a fixed value
    ib = 12'h3A0;
    {fl, s} = add_exp(acc_m, i_aie_mem_model.mem[12'h3B0]);
    acc_m = s;
    issue(16'h2410, 4'h0, 1'b1, 1, 1);
    chk({3'h0, flags, acc}, {3'h0, fl, s});
    $display("index base done");
    // reset lands while an add is in flight
    @(negedge clk_sys);
    instr_word = 16'h0F40;
    instr_valid = 1'b1;
    @(negedge clk_sys);
    instr_valid = 1'b0;
    rst_b = 1'b0;
    @(negedge clk_sys);
    chk({7'h00, busy_ff, acc}, 16'h0000);
    chk({11'h000, flags}, 16'h0000);
    rst_b = 1'b1;
    {fl, s} = add_exp(8'h00, 8'h22);
    issue(16'h0F22, 4'h0, 1'b0, 1, 1);
    chk({3'h0, flags, acc}, {3'h0, fl, s});
    $display("reset abort done");
    // sum wraps to zero: zero, carry and digit carry all set
    {fl, s} = add_exp(8'h22, 8'hDE);
    issue(16'h0FDE, 4'h0, 1'b0, 1, 1);
    chk({3'h0, flags, acc}, {3'h0, fl, s});
    $display("zero result done");
    test_done();
  end
endmodule
